// file: include/scx_pkg.sv
// constants, opcodes and field layouts for the command-list load/store executor
package scx_pkg;

  // command word layout
  localparam int OPC_HI = 15;                     // operation code, top bit
  localparam int OPC_LO = 11;                     // operation code, bottom bit
  localparam int ARG_HI = 10;                     // argument field, top bit

  // operation codes handled by this block
  localparam logic [4:0] OPC_OP_SETTINGS_FETCH = 5'h00;
  localparam logic [4:0] OPC_XPTR_FETCH        = 5'h02;
  localparam logic [4:0] OPC_YPTR_FETCH        = 5'h03;
  localparam logic [4:0] OPC_ZPTR_FETCH        = 5'h04;
  localparam logic [4:0] OPC_ACC_COMPLEX_FETCH = 5'h05;
  localparam logic [4:0] OPC_LOOP_COUNT_FETCH  = 5'h06;
  localparam logic [4:0] OPC_OFFCHIP_BASE_FETCH = 5'h07;
  localparam logic [4:0] OPC_XPTR_SAVE         = 5'h0A;
  localparam logic [4:0] OPC_EXTENDED_OP_CLASS = 5'h10;
  localparam logic [4:0] OPC_XPTR_LOW_SAVE     = 5'h1C;
  localparam logic [10:0] SUB_ACC_WIDE_FETCH   = 11'h533;

  // vector pointer fields
  localparam int PTR_ADDR_LO   = 0;               // 16-bit word address
  localparam int PTR_STRIDE_LO = 16;              // 4-bit stride exponent
  localparam int PTR_WRAP_LO   = 20;              // 5-bit wrap exponent

  // operation settings fields
  localparam int SET_COUNT_LO  = 0;               // 16-bit vector count
  localparam int SET_ROUND_BIT = 16;              // rounding control
  localparam int SET_ZERO_BIT  = 17;              // clear accumulator first

  // accumulator layout
  localparam int ACC_W         = 34;
  localparam int ACC_ROUND_POS = 14;
  localparam int ACC_DATA_LO   = 15;

  // register port offsets (byte addresses)
  localparam logic [5:0] REG_START     = 6'h00;
  localparam logic [5:0] REG_STATUS    = 6'h04;
  localparam logic [5:0] REG_ABORT     = 6'h08;
  localparam logic [5:0] REG_XPTR      = 6'h0C;
  localparam logic [5:0] REG_YPTR      = 6'h10;
  localparam logic [5:0] REG_ZPTR      = 6'h14;
  localparam logic [5:0] REG_SETTINGS  = 6'h18;
  localparam logic [5:0] REG_LOOP      = 6'h1C;
  localparam logic [5:0] REG_BASE      = 6'h20;
  localparam logic [5:0] REG_ACC_RE    = 6'h24;
  localparam logic [5:0] REG_ACC_IM    = 6'h28;
  localparam int STAT_RUN_BIT    = 0;
  localparam int STAT_BAD_OP_BIT = 1;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_HALF = 16'h0000;

  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_CMD_REQ = 8'h02,
    ST_CMD_DEC = 8'h04,
    ST_RD_LO   = 8'h08,
    ST_RD_HI   = 8'h10,
    ST_WR_HI   = 8'h20,
    ST_WR_END  = 8'h40,
    ST_RD_END  = 8'h80
  } scx_state_t;

endpackage : scx_pkg

// file: rtl/scx_extended_op_class.sv
// command-list sequencer for the register load and store instruction group
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Functional notes
// RULE1: opcode bits 15-11, argument bits 10-0
// RULE2: low half bits 0-15, high 16-31
// RULE3: double-word addresses even, 16-bit space
// RULE4: element address is wrapped base plus offset
// RULE5: software loads vector count above zero
// RULE6: pointer/settings/base change only by loads
// RULE7: software assumes accumulator unpredictable after instructions
// RULE8: non-complex loads write both accumulator parts
// RULE9: rounding bit copied to accumulator bit 14
// RULE10: clear-first seeds accumulator with rounding bit
// RULE11: no rounding for integer or extended data
// RULE12: real-X product accumulates before imaginary-X
// RULE13: software avoids reading freshly written data
// RULE14: reserved code halts, raises trap, sets flag
// RULE15: opcodes 2,3,4 fetch X,Y,Z pointers
// RULE16: complex load fills accumulator bits 15-30
// RULE17: complex load sets bit 14 from rounding
// RULE18: extended sub-op loads X element 0
// RULE19: memory bits 1-31 to accumulator 0-30
// RULE20: opcode 0 fetches operation settings
// RULE21: opcodes 6,7 fetch loop count, base
// RULE22: software keeps base bits 0-16 zero
// RULE23: opcode 0A saves X, 1C low half
// RULE24: extended class argument selects sub-operation
module scx_extended_op_class
  import scx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [5:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic      [15:0]       mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic      [15:0]       mem_wdata,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mac_begin,
  input  wire logic              mac_xre_valid,
  input  wire logic [ACC_W-1:0]  mac_xre_re,
  input  wire logic [ACC_W-1:0]  mac_xre_im,
  input  wire logic              mac_xim_valid,
  input  wire logic [ACC_W-1:0]  mac_xim_re,
  input  wire logic [ACC_W-1:0]  mac_xim_im,
  output logic      [ACC_W-1:0]  acc_re,
  output logic      [ACC_W-1:0]  acc_im,
  output logic                   run,
  output logic                   nmi_req,
  output logic                   halt_pulse
);
  import scx_pkg::*;

  // sequencer and register state
  scx_state_t       state_ff,     nxt_state;
  logic [15:0]      pc_ff,        nxt_pc;         // next command word address
  logic [15:0]      cmd_ff,       nxt_cmd;        // command being executed
  logic [15:0]      lo_ff,        nxt_lo;         // low half of a double-word fetch
  logic [31:0]      xptr_ff,      nxt_xptr;
  logic [31:0]      yptr_ff,      nxt_yptr;
  logic [31:0]      zptr_ff,      nxt_zptr;
  logic [31:0]      settings_ff,  nxt_settings;
  logic [31:0]      loop_ff,      nxt_loop;
  logic [31:0]      base_ff,      nxt_base;
  logic [ACC_W-1:0] acc_re_ff,    nxt_acc_re;
  logic [ACC_W-1:0] acc_im_ff,    nxt_acc_im;
  logic             bad_op_ff,    nxt_bad_op;     // sticky undefined-operation flag
  logic             nmi_ff,       nxt_nmi;
  logic             halt_ff,      nxt_halt;
  logic [15:0]      maddr_ff,     nxt_maddr;
  logic             mrd_ff,       nxt_mrd;
  logic             mwr_ff,       nxt_mwr;
  logic [15:0]      mwdata_ff,    nxt_mwdata;
  logic [31:0]      rdata_ff,     nxt_rdata;

  // decode helpers
  logic [4:0]       opc;                          // opcode of the word just fetched
  logic [10:0]      arg;
  logic [15:0]      arg_addr;
  logic             dword_op;                     // opcode needs an even address
  logic             run_now;

  // mask of the k low bits of a 16-bit address
  function automatic logic [15:0] low_mask(input logic [4:0] k);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      if (i < int'(k))
      begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : low_mask

  // word address of element n of a cyclic vector
  function automatic logic [15:0] elem_addr(input logic [31:0] ptr, input logic [15:0] n);
    logic [15:0] a;
    logic [3:0]  stride;
    logic [4:0]  wrap;
    logic [15:0] base;
    logic [15:0] off;
    a      = ptr[PTR_ADDR_LO +: 16];
    stride = ptr[PTR_STRIDE_LO +: 4];
    wrap   = ptr[PTR_WRAP_LO +: 5];
    // a wrap of zero would underflow; treat it as clearing nothing
    base   = a & ~low_mask((wrap == 5'h00) ? 5'h00 : 5'(wrap - 5'h01)); // RULE4
    off    = 16'(a + (n << stride)) & low_mask(wrap);                   // RULE4
    return 16'(base + off);
  endfunction : elem_addr

  // place a 16-bit part into accumulator bits 15-30 with sign fill above
  function automatic logic [ACC_W-1:0] acc_part(input logic [15:0] v, input logic rnd);
    logic [ACC_W-1:0] r;
    r = {{(ACC_W-31){v[15]}}, v, rnd, 14'h0000}; // RULE16 RULE17
    return r;
  endfunction : acc_part

  // combinational decode of the fetched command word
  always_comb
  begin
    opc      = mem_rdata[OPC_HI:OPC_LO];                        // RULE1
    arg      = mem_rdata[ARG_HI:0];                             // RULE1
    arg_addr = {5'h00, arg};
    dword_op = (opc != OPC_XPTR_LOW_SAVE) && (opc != OPC_EXTENDED_OP_CLASS);
    run_now  = (state_ff != ST_IDLE);
  end

  // next-state logic for the sequencer, registers and ports
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_pc       = pc_ff;
    nxt_cmd      = cmd_ff;
    nxt_lo       = lo_ff;
    nxt_xptr     = xptr_ff;       // RULE6
    nxt_yptr     = yptr_ff;
    nxt_zptr     = zptr_ff;
    nxt_settings = settings_ff;
    nxt_loop     = loop_ff;
    nxt_base     = base_ff;
    nxt_acc_re   = acc_re_ff;
    nxt_acc_im   = acc_im_ff;
    nxt_bad_op   = bad_op_ff;
    nxt_nmi      = 1'b0;
    nxt_halt     = 1'b0;
    nxt_maddr    = maddr_ff;
    nxt_mrd      = 1'b0;
    nxt_mwr      = 1'b0;
    nxt_mwdata   = mwdata_ff;
    nxt_rdata    = RST_WORD;

    // accumulator service for the multiply unit
    if (mac_begin && settings_ff[SET_ZERO_BIT])
    begin
      // clear-first seeds the rounding bit into a zero accumulator
      nxt_acc_re = ACC_W'({settings_ff[SET_ROUND_BIT], 14'h0000}); // RULE10 RULE9
      nxt_acc_im = ACC_W'({settings_ff[SET_ROUND_BIT], 14'h0000});
    end
    // the real-X product goes in first, then the imaginary-X product
    nxt_acc_re = ACC_W'(nxt_acc_re + (mac_xre_valid ? mac_xre_re : '0)); // RULE12
    nxt_acc_im = ACC_W'(nxt_acc_im + (mac_xre_valid ? mac_xre_im : '0));
    nxt_acc_re = ACC_W'(nxt_acc_re + (mac_xim_valid ? mac_xim_re : '0)); // RULE12
    nxt_acc_im = ACC_W'(nxt_acc_im + (mac_xim_valid ? mac_xim_im : '0));

    case (state_ff)
      ST_IDLE:
      begin
        // a write of the start register launches the list
        if (reg_wr && reg_addr == REG_START)
        begin
          nxt_pc    = reg_wdata[15:0];
          nxt_maddr = reg_wdata[15:0];
          nxt_mrd   = 1'b1;
          nxt_state = ST_CMD_REQ;
        end
      end
      ST_CMD_REQ:
      begin
        // fetch strobe is out; word arrives next cycle
        nxt_state = ST_CMD_DEC;
      end
      ST_CMD_DEC:
      begin
        nxt_cmd = mem_rdata;
        nxt_pc  = 16'(pc_ff + 16'h0001);
        if (dword_op && arg[0])
        begin
          // odd double-word address traps
          nxt_bad_op = 1'b1;                                   // RULE3
          nxt_nmi    = 1'b1;
          nxt_halt   = 1'b1;
          nxt_state  = ST_IDLE;
        end
        else
        begin
          case (opc)
            OPC_OP_SETTINGS_FETCH, OPC_XPTR_FETCH, OPC_YPTR_FETCH, OPC_ZPTR_FETCH,
            OPC_ACC_COMPLEX_FETCH, OPC_LOOP_COUNT_FETCH, OPC_OFFCHIP_BASE_FETCH:
            begin
              nxt_maddr = arg_addr;                            // RULE15 RULE20 RULE21
              nxt_mrd   = 1'b1;
              nxt_state = ST_RD_LO;
            end
            OPC_XPTR_SAVE:
            begin
              nxt_maddr  = arg_addr;
              nxt_mwdata = xptr_ff[15:0];                      // RULE23 RULE2
              nxt_mwr    = 1'b1;
              nxt_state  = ST_WR_HI;
            end
            OPC_XPTR_LOW_SAVE:
            begin
              nxt_maddr  = arg_addr;
              nxt_mwdata = xptr_ff[15:0];                      // RULE23
              nxt_mwr    = 1'b1;
              nxt_state  = ST_WR_END;
            end
            OPC_EXTENDED_OP_CLASS:
            begin
              // the whole argument selects a sub-operation here
              if (arg == SUB_ACC_WIDE_FETCH)                   // RULE24
              begin
                nxt_maddr = elem_addr(xptr_ff, RST_HALF);      // RULE18
                nxt_mrd   = 1'b1;
                nxt_state = ST_RD_LO;
              end
              else
              begin
                nxt_bad_op = 1'b1;                             // RULE14
                nxt_nmi    = 1'b1;
                nxt_halt   = 1'b1;
                nxt_state  = ST_IDLE;
              end
            end
            default:
            begin
              // reserved code: stop the list and raise the trap
              nxt_bad_op = 1'b1;                               // RULE14
              nxt_nmi    = 1'b1;
              nxt_halt   = 1'b1;
              nxt_state  = ST_IDLE;
            end
          endcase
        end
      end
      ST_RD_LO:
      begin
        // low word still in flight; ask for the high word
        nxt_maddr = 16'(maddr_ff + 16'h0001);
        nxt_mrd   = 1'b1;
        nxt_state = ST_RD_HI;
      end
      ST_RD_HI:
      begin
        // low word arrives now, high word next cycle
        nxt_lo    = mem_rdata;                                 // RULE2
        nxt_state = ST_RD_END;
      end
      ST_RD_END:
      begin
        // commit the double-word, then fetch the next command
        case (cmd_ff[OPC_HI:OPC_LO])
          OPC_OP_SETTINGS_FETCH:  nxt_settings = {mem_rdata, lo_ff}; // RULE20
          OPC_XPTR_FETCH:         nxt_xptr     = {mem_rdata, lo_ff}; // RULE15
          OPC_YPTR_FETCH:         nxt_yptr     = {mem_rdata, lo_ff}; // RULE15
          OPC_ZPTR_FETCH:         nxt_zptr     = {mem_rdata, lo_ff}; // RULE15
          OPC_LOOP_COUNT_FETCH:   nxt_loop     = {mem_rdata, lo_ff}; // RULE21
          OPC_OFFCHIP_BASE_FETCH: nxt_base     = {mem_rdata, lo_ff}; // RULE21
          OPC_ACC_COMPLEX_FETCH:
          begin
            // real part from the even word, imaginary from the odd word
            nxt_acc_re = acc_part(lo_ff, settings_ff[SET_ROUND_BIT]);     // RULE16 RULE9
            nxt_acc_im = acc_part(mem_rdata, settings_ff[SET_ROUND_BIT]); // RULE17
          end
          default:
          begin
            // extended load: no rounding bit, both parts written alike
            nxt_acc_re = {{(ACC_W-31){mem_rdata[15]}}, mem_rdata, lo_ff[15:1]}; // RULE19 RULE11
            nxt_acc_im = {{(ACC_W-31){mem_rdata[15]}}, mem_rdata, lo_ff[15:1]}; // RULE8
          end
        endcase
        nxt_maddr = pc_ff;
        nxt_mrd   = 1'b1;
        nxt_state = ST_CMD_REQ;
      end
      ST_WR_HI:
      begin
        // second half of a pointer save
        nxt_maddr  = 16'(maddr_ff + 16'h0001);
        nxt_mwdata = xptr_ff[31:16];                           // RULE23 RULE2
        nxt_mwr    = 1'b1;
        nxt_state  = ST_WR_END;
      end
      ST_WR_END:
      begin
        nxt_maddr = pc_ff;
        nxt_mrd   = 1'b1;
        nxt_state = ST_CMD_REQ;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase

    // abort wins over any step in progress; a pending store may be lost
    if (run_now && reg_wr && reg_addr == REG_ABORT)
    begin
      nxt_state = ST_IDLE;
      nxt_mrd   = 1'b0;
      nxt_mwr   = 1'b0;
      nxt_halt  = 1'b1;
    end

    // software clears the flag by writing one; a trap in the same cycle wins
    if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_BAD_OP_BIT] && !nxt_nmi)
    begin
      nxt_bad_op = 1'b0;
    end

    // register read port, data valid only in the following cycle
    if (reg_rd)
    begin
      case (reg_addr)
        REG_START:    nxt_rdata = {16'h0000, pc_ff};
        REG_STATUS:   nxt_rdata = {30'h0000_0000, bad_op_ff, run_now};
        REG_XPTR:     nxt_rdata = xptr_ff;
        REG_YPTR:     nxt_rdata = yptr_ff;
        REG_ZPTR:     nxt_rdata = zptr_ff;
        REG_SETTINGS: nxt_rdata = settings_ff;
        REG_LOOP:     nxt_rdata = loop_ff;
        REG_BASE:     nxt_rdata = base_ff;
        REG_ACC_RE:   nxt_rdata = acc_re_ff[31:0];
        REG_ACC_IM:   nxt_rdata = acc_im_ff[31:0];
        default:      nxt_rdata = RST_WORD;
      endcase
    end
  end

  // register stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff    <= ST_IDLE;
      pc_ff       <= RST_HALF;
      cmd_ff      <= RST_HALF;
      lo_ff       <= RST_HALF;
      xptr_ff     <= RST_WORD;
      yptr_ff     <= RST_WORD;
      zptr_ff     <= RST_WORD;
      settings_ff <= RST_WORD;
      loop_ff     <= RST_WORD;
      base_ff     <= RST_WORD;
      acc_re_ff   <= '0;
      acc_im_ff   <= '0;
      bad_op_ff   <= 1'b0;
      nmi_ff      <= 1'b0;
      halt_ff     <= 1'b0;
      maddr_ff    <= RST_HALF;
      mrd_ff      <= 1'b0;
      mwr_ff      <= 1'b0;
      mwdata_ff   <= RST_HALF;
      rdata_ff    <= RST_WORD;
    end
    else
    begin
      state_ff    <= nxt_state;
      pc_ff       <= nxt_pc;
      cmd_ff      <= nxt_cmd;
      lo_ff       <= nxt_lo;
      xptr_ff     <= nxt_xptr;
      yptr_ff     <= nxt_yptr;
      zptr_ff     <= nxt_zptr;
      settings_ff <= nxt_settings;
      loop_ff     <= nxt_loop;
      base_ff     <= nxt_base;
      acc_re_ff   <= nxt_acc_re;
      acc_im_ff   <= nxt_acc_im;
      bad_op_ff   <= nxt_bad_op;
      nmi_ff      <= nxt_nmi;
      halt_ff     <= nxt_halt;
      maddr_ff    <= nxt_maddr;
      mrd_ff      <= nxt_mrd;
      mwr_ff      <= nxt_mwr;
      mwdata_ff   <= nxt_mwdata;
      rdata_ff    <= nxt_rdata;
    end
  end

  // outputs straight from flops, except run, which is decoded from the state flops
  assign reg_rdata  = rdata_ff;
  assign mem_addr   = maddr_ff;
  assign mem_rd     = mrd_ff;
  assign mem_wr     = mwr_ff;
  assign mem_wdata  = mwdata_ff;
  assign acc_re     = acc_re_ff;
  assign acc_im     = acc_im_ff;
  assign run        = (state_ff != ST_IDLE);
  assign nmi_req    = nmi_ff;
  assign halt_pulse = halt_ff;

endmodule : scx_extended_op_class

// file: test/scx_monitor.sv
// port-level checks for the command-list executor
`timescale 1ns/1ps
module scx_monitor
  import scx_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input logic      [15:0] mem_addr,
  input logic             mem_rd,
  input logic             mem_wr,
  input logic [ACC_W-1:0] acc_re,
  input logic [ACC_W-1:0] acc_im,
  input logic             run,
  input logic             nmi_req,
  input logic             halt_pulse,
  input wire logic        mac_begin,
  input wire logic        mac_xre_valid,
  input wire logic        mac_xim_valid
);
  logic [15:0] start_lo;  // list start word carried by a start write
  logic        mac_any;   // any multiply-unit activity this cycle
  assign start_lo = reg_wdata[15:0];
  assign mac_any = mac_begin | mac_xre_valid | mac_xim_valid;

  default clocking mc @(posedge clk);
  endclocking
  default disable iff (rst);

  // a trap is a stop: pulse, halt and idle together, for one cycle
  a_trap_halts_run: assert property (nmi_req |-> halt_pulse && !run)
    else $error("trap without halt");
  a_trap_one_pulse: assert property (nmi_req |=> !nmi_req)
    else $error("trap pulse too long");
  a_stop_gives_halt: assert property ($fell(run) |-> halt_pulse)
    else $error("run fell without halt");
  a_halt_one_idle: assert property (halt_pulse |-> !run ##1 !halt_pulse)
    else $error("halt pulse wrong");
  // a start write fetches the first command word from the written address
  a_start_cmd_fetch: assert property ((reg_wr && reg_addr == REG_START && !run)
    |=> mem_rd && run && mem_addr == $past(start_lo))
    else $error("start fetch wrong");
  // a double-word store goes low word even, high word next
  a_store_dword_pair: assert property (mem_wr && $past(mem_wr)
    |-> mem_addr == $past(mem_addr) + 16'h0001 && mem_addr[0])
    else $error("double-word store order wrong");
  a_mem_one_dir: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  // idle and no multiply activity: accumulator must not move
  a_acc_idle_hold: assert property (!run && !$past(run) && !$past(mac_any)
    |-> $stable(acc_re) && $stable(acc_im))
    else $error("accumulator moved while idle");
  a_idle_no_access: assert property (!run && !$past(run) |-> !mem_rd && !mem_wr)
    else $error("memory access while idle");

  c_trap: cover property (nmi_req);
  c_abort: cover property ($fell(run) && !nmi_req);
  c_store_pair: cover property (mem_wr ##1 mem_wr);
  c_mac: cover property (mac_begin);
endmodule : scx_monitor

// file: test/scx_ram_model.sv
// internal RAM behind the executor: answers a read in the next cycle
`timescale 1ns/1ps
module scx_ram_model
(
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] mem [0:65535];  // whole 16-bit word space
  initial
  begin
    mem_rdata = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // outside an answer the bus toggles, so stale data is never mistaken
  always @(posedge clk)
  begin
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
  end
endmodule : scx_ram_model

// file: test/testbench.sv
// self-checking bench for the command-list executor
`timescale 1ns/1ps
module testbench;
  import scx_pkg::*;
  logic             clk, rst, reg_wr, reg_rd, mem_rd, mem_wr, run, nmi_req, halt_pulse;
  logic             mac_begin, mac_xre_valid, mac_xim_valid;
  logic [5:0]       reg_addr;
  logic [31:0]      reg_wdata, reg_rdata;
  logic [15:0]      mem_addr, mem_wdata, mem_rdata;
  logic [ACC_W-1:0] mac_xre_re, mac_xre_im, mac_xim_re, mac_xim_im, acc_re, acc_im;
  int               num_errors;
  int               tests_run;
  logic             nmi_seen;  // trap seen in the last list
  localparam logic [4:0] LD_OPS [6] = '{OPC_XPTR_FETCH, OPC_YPTR_FETCH, OPC_ZPTR_FETCH,
    OPC_OP_SETTINGS_FETCH, OPC_LOOP_COUNT_FETCH, OPC_OFFCHIP_BASE_FETCH};
  localparam logic [5:0] LD_REG [6] = '{REG_XPTR, REG_YPTR, REG_ZPTR, REG_SETTINGS, REG_LOOP, REG_BASE};
  // count above zero, base bits 0-16 zero
  localparam logic [31:0] LD_VAL [6] = '{32'h0051_2468, 32'h0172_1357, 32'h0093_0ACE,
    32'h0003_0004, 32'h0000_0009, 32'hABCE_0000};
  // reserved, odd address, unknown sub-operation
  localparam logic [15:0] BAD_CMD [3] = '{16'h0800, 16'h1A03, 16'h8534};

  scx_extended_op_class dut (.*);
  scx_ram_model ram_i (.*);

  always #50 clk = ~clk;

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // data taken in the cycle after the strobe
  task automatic reg_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  task automatic put_dw(input logic [15:0] a, input logic [31:0] v);
    ram_i.mem[a] = v[15:0];
    ram_i.mem[a + 16'h0001] = v[31:16];
  endtask : put_dw

  task automatic put_cmd(input logic [15:0] a, input logic [4:0] op, input logic [10:0] arg);
    ram_i.mem[a] = {op, arg};
  endtask : put_cmd

  // harmless loads keep a list busy
  task automatic pad(input logic [15:0] a);
    for (int k = 0; k < 12; k++)
      put_cmd(a + 16'(k), OPC_XPTR_FETCH, 11'h234);
  endtask : pad

  // clear flag, start, maybe abort, await stop
  task automatic run_list(input logic [15:0] start, input int ab);
    reg_write(REG_STATUS, 32'h0000_0002);
    reg_write(REG_START, {16'h0000, start});
    nmi_seen = 1'b0;
    if (ab > 0)
    begin
      repeat (ab) @(posedge clk);
      reg_write(REG_ABORT, 32'h0000_0001);
    end
    repeat (300)
    begin
      #1;
      if (nmi_req === 1'b1) nmi_seen = 1'b1;
      if (halt_pulse === 1'b1) break;
      @(posedge clk);
    end
    check(halt_pulse, 1'b1);
  endtask : run_list

  task automatic t_reset();
    logic [31:0] d;
    reg_write(REG_ACC_RE, 32'hFFFF_FFFF);
    foreach (LD_REG[i])
    begin
      reg_read(LD_REG[i], d);
      check(d, RST_WORD);
    end
    reg_read(REG_ACC_RE, d);
    check(d, RST_WORD);
    reg_read(6'h2C, d);
    check(d, RST_WORD);
  endtask : t_reset

  task automatic t_loads();
    logic [31:0] d;
    for (int i = 0; i < 6; i++)
    begin
      put_dw(16'h0200 + 16'(2 * i), LD_VAL[i]);
      put_cmd(16'h0100 + 16'(i), LD_OPS[i], 11'h200 + 11'(2 * i));
    end
    put_cmd(16'h0106, 5'h01, 11'h000);
    run_list(16'h0100, 0);
    check(nmi_seen, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      reg_read(LD_REG[i], d);
      check(d, LD_VAL[i]);
    end
    reg_read(REG_STATUS, d);
    check(d, 32'h0000_0002);
    check(acc_re, RST_WORD);
  endtask : t_loads

  task automatic t_traps();
    logic [31:0] d;
    for (int k = 0; k < 3; k++)
    begin
      ram_i.mem[16'h01A0] = BAD_CMD[k];
      run_list(16'h01A0, 0);
      check(nmi_seen, 1'b1);
      reg_read(REG_STATUS, d);
      check(d, 32'h0000_0002);
      reg_read(REG_YPTR, d);
      check(d, LD_VAL[1]);
    end
  endtask : t_traps

  task automatic t_store();
    logic [31:0] d;
    put_dw(16'h0240, 32'h00F0_5A3C);
    put_dw(16'h0250, 32'hFFFF_FFFF);
    ram_i.mem[16'h0255] = 16'hFFFF;
    put_cmd(16'h0180, OPC_XPTR_FETCH, 11'h240);
    put_cmd(16'h0181, OPC_XPTR_SAVE, 11'h250);
    put_cmd(16'h0182, OPC_XPTR_LOW_SAVE, 11'h255);
    put_cmd(16'h0183, 5'h01, 11'h000);
    run_list(16'h0180, 0);
    check(ram_i.mem[16'h0250], 16'h5A3C);
    check(ram_i.mem[16'h0251], 16'h00F0);
    check(ram_i.mem[16'h0255], 16'h5A3C);
    reg_read(REG_XPTR, d);
    check(d, 32'h00F0_5A3C);
  endtask : t_store

  // accumulator loads, ended by abort
  task automatic t_acc();
    logic [31:0] d;
    put_dw(16'h0234, {7'h00, 5'h03, 4'h0, 16'h013E});
    for (int r = 0; r < 2; r++)
    begin
      put_dw(16'h0230, {15'h0000, 1'(r), 16'h0004});
      put_dw(16'h0232, 32'hF00D_1234);
      put_cmd(16'h0400, OPC_OP_SETTINGS_FETCH, 11'h230);
      put_cmd(16'h0401, OPC_ACC_COMPLEX_FETCH, 11'h232);
      pad(16'h0402);
      run_list(16'h0400, 40);
      check(acc_re[30:0], {16'h1234, 1'(r), 14'h0000});
      check(acc_im[30:0], {16'hF00D, 1'(r), 14'h0000});
    end
    // wrap 3: base 013C, offset 6
    d = 32'hA5C3_7E19;
    put_dw(16'h0142, d);
    put_cmd(16'h0420, OPC_XPTR_FETCH, 11'h234);
    ram_i.mem[16'h0421] = {OPC_EXTENDED_OP_CLASS, SUB_ACC_WIDE_FETCH};
    pad(16'h0422);
    run_list(16'h0420, 40);
    check(nmi_seen, 1'b0);
    check(acc_re[30:0], d[31:1]);
    check(acc_im[30:0], d[31:1]);
    reg_read(REG_STATUS, d);
    check(d, 32'h0000_0000);
  endtask : t_acc

  task automatic t_mac(input logic [31:0] cfg, input logic fresh);
    logic [33:0] re0;
    logic [33:0] im0;
    put_dw(16'h0236, cfg);
    put_cmd(16'h01C0, OPC_OP_SETTINGS_FETCH, 11'h236);
    put_cmd(16'h01C1, 5'h01, 11'h000);
    run_list(16'h01C0, 0);
    re0 = fresh ? 34'h0_4000 : acc_re;
    im0 = fresh ? 34'h0_4000 : acc_im;
    mac_xre_re <= 34'h0_0005;
    mac_xre_im <= 34'h0_0007;
    mac_xim_re <= 34'h0_0100;
    mac_xim_im <= 34'h0_0200;
    mac_begin <= 1'b1;
    @(posedge clk);
    mac_begin <= 1'b0;
    mac_xre_valid <= 1'b1;
    @(posedge clk);
    mac_xre_valid <= 1'b0;
    mac_xim_valid <= 1'b1;
    @(posedge clk);
    mac_xim_valid <= 1'b0;
    @(posedge clk);
    #1;
    check(acc_re, re0 + 34'h0_0105);
    check(acc_im, im0 + 34'h0_0207);
  endtask : t_mac

  task automatic final_report();
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_wr, reg_rd, mac_begin, mac_xre_valid, mac_xim_valid} = 5'h00;
    reg_addr = 6'h00;
    reg_wdata = 32'h0000_0000;
    {mac_xre_re, mac_xre_im, mac_xim_re, mac_xim_im} = 136'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_loads();
    t_traps();
    t_store();
    t_acc();
    t_mac(32'h0003_0001, 1'b1);
    t_mac(32'h0001_0001, 1'b0);
    final_report();
  end

  // a few hundred cycles expected
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : testbench

bind scx_extended_op_class scx_monitor mon (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .acc_re(acc_re),
  .acc_im(acc_im), .run(run), .nmi_req(nmi_req), .halt_pulse(halt_pulse), .mac_begin(mac_begin),
  .mac_xre_valid(mac_xre_valid), .mac_xim_valid(mac_xim_valid));
